/* File: core/pad_top.sv */
// Pacing artifact detector: register file, lead forming, three detectors, raw stream.
// Assumes 128 kHz channel samples with a strobe and a frame start from the framer.
`timescale 1ns/10ps
`default_nettype none
module pad_top (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_unit,
    input wire logic [5:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    output logic [23:0] reg_rdata,
    // Channel samples before gain calibration.
    input wire logic sample_stb,
    input wire logic signed [15:0] ch1_raw,
    input wire logic signed [15:0] ch2_raw,
    input wire logic signed [15:0] ch3_raw,
    input wire logic [1:0] gain_sel,
    // Frame header.
    input wire logic frame_start,
    output logic [2:0] header_pace_flags,
    // Secondary serial port and general pins.
    input wire logic sec_port_en,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe
);
    import pad_pkg::*;
    localparam int NCH = 3;
    // =====================================================================
    // Registers: one threshold set per detector, one shared control register.
    logic [7:0] height_th_r [NCH];
    logic [7:0] edge_th_r [NCH];
    logic [7:0] level_th_r [NCH];
    logic [11:0] control_r;
    logic [NCH-1:0] pulse;
    logic [7:0] width [NCH];
    logic [15:0] height [NCH];
    logic [NCH-1:0] pending_r;
    logic signed [15:0] lead [NCH];
    logic [1:0] ui;
    assign ui = (reg_unit == 2'h3) ? 2'h0 : reg_unit;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                height_th_r[i] <= PAD_HEIGHT_TH_RST;
                edge_th_r[i] <= PAD_EDGE_TH_RST;
                level_th_r[i] <= PAD_LEVEL_TH_RST;
            end
            control_r <= PAD_CONTROL_RST;
        end else if (clk_en && reg_wr) begin
            unique case (reg_addr)
                PAD_ADDR_HEIGHT_TH: height_th_r[ui] <= reg_wdata[7:0];
                PAD_ADDR_EDGE_TH: edge_th_r[ui] <= reg_wdata[7:0];
                PAD_ADDR_LEVEL_TH: level_th_r[ui] <= reg_wdata[7:0];
                PAD_ADDR_CONTROL: control_r <= reg_wdata[11:0];
                default: ;
            endcase
        end
    end
    // =====================================================================
    // Lead forming from the channel samples.
    function automatic logic signed [15:0] form_lead(input logic [1:0] sel,
            input logic signed [15:0] c1, input logic signed [15:0] c2,
            input logic signed [15:0] c3);
        logic signed [16:0] t;
        t = '0;
        unique case (sel)
            PAD_LEAD_I: t = 17'(c1) - 17'(c3);
            PAD_LEAD_II: t = 17'(c2) - 17'(c3);
            PAD_LEAD_III: t = 17'(c2) - 17'(c1);
            PAD_LEAD_AVF: t = 17'(c2) - ((17'(c1) + 17'(c3)) >>> 1);
        endcase
        form_lead = t[15:0];
    endfunction
    for (genvar g = 0; g < NCH; g++) begin : g_det
        assign lead[g] = form_lead(control_r[PAD_SEL_LSB+2*g +: 2], ch1_raw, ch2_raw, ch3_raw);
        pad_channel u_det (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .sample_stb(sample_stb),
            .lead_sample(lead[g]),
            .enable(control_r[PAD_EN_LSB+g]),
            .height_th(height_th_r[g]),
            .edge_th(edge_th_r[g]),
            .level_th(level_th_r[g]),
            .gain_sel(gain_sel),
            .vf1_en(control_r[PAD_VF1_BIT]),
            .vf2_en(control_r[PAD_VF2_BIT]),
            .wf_en(control_r[PAD_WF_BIT]),
            .pace_pulse(pulse[g]),
            .width_r(width[g]),
            .height_r(height[g])
        );
    end
    // =====================================================================
    // Flags held until the next frame header; a pulse in the frame start cycle goes into that header.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pending_r <= '0;
            header_pace_flags <= '0;
        end else if (clk_en) begin
            if (frame_start) begin
                header_pace_flags <= pending_r | pulse;
                pending_r <= '0;
            end else begin
                pending_r <= pending_r | pulse;
            end
        end
    end
    // =====================================================================
    // Read data: summary word of seven bits and extended words.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (clk_en && reg_rd) begin
            if (reg_addr == PAD_ADDR_RESULT) begin
                reg_rdata <= {17'h0, width[0][7:4], height[0][15:13]};
            end else if (reg_addr >= PAD_ADDR_EXT0 && reg_addr < PAD_ADDR_EXT0 + 6'h3) begin
                reg_rdata <= {width[reg_addr[1:0] - 2'h2], height[reg_addr[1:0] - 2'h2]};
            end else if (reg_addr == PAD_ADDR_HEIGHT_TH) begin
                reg_rdata <= {16'h0, height_th_r[ui]};
            end else if (reg_addr == PAD_ADDR_EDGE_TH) begin
                reg_rdata <= {16'h0, edge_th_r[ui]};
            end else if (reg_addr == PAD_ADDR_LEVEL_TH) begin
                reg_rdata <= {16'h0, level_th_r[ui]};
            end else if (reg_addr == PAD_ADDR_CONTROL) begin
                reg_rdata <= {12'h0, control_r};
            end else begin
                reg_rdata <= '0;
            end
        end
    end
    // =====================================================================
    // Secondary master port: data, frame and busy on three pins, raw samples.
    logic [5:0] bit_r;
    logic [47:0] shift_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bit_r <= '0;
            shift_r <= '0;
            pin_out <= '0;
            pin_oe <= '0;
        end else if (clk_en) begin
            if (sec_port_en && sample_stb) begin
                shift_r <= {ch1_raw, ch2_raw, ch3_raw};
                bit_r <= 6'd48;
            end else if (bit_r != 6'h00) begin
                shift_r <= {shift_r[46:0], 1'b0};
                bit_r <= bit_r - 6'h01;
            end
            if (sec_port_en) begin
                pin_out <= {gpio_out[3], shift_r[47], bit_r == 6'd48, bit_r != 6'h00};
                pin_oe <= {gpio_oe[3], 3'b111};
            end else begin
                pin_out <= gpio_out;
                pin_oe <= gpio_oe;
            end
        end
    end
endmodule
`default_nettype wire

/* File: include/pad_pkg.sv */
// Package for the pacing artifact detector: register map, fields, timing.
// Assumes a 200 MHz system clock and a 128 kHz sample strobe from the decimation chain.
package pad_pkg;
    // =====================================================================
    // Register indices.
    localparam logic [5:0] PAD_ADDR_HEIGHT_TH = 6'h07;
    localparam logic [5:0] PAD_ADDR_EDGE_TH = 6'h0E;
    localparam logic [5:0] PAD_ADDR_LEVEL_TH = 6'h0F;
    localparam logic [5:0] PAD_ADDR_CONTROL = 6'h04;
    localparam logic [5:0] PAD_ADDR_RESULT = 6'h1A;
    localparam logic [5:0] PAD_ADDR_EXT0 = 6'h3A;
    // =====================================================================
    // Reset values.
    localparam logic [7:0] PAD_HEIGHT_TH_RST = 8'h24;
    localparam logic [7:0] PAD_EDGE_TH_RST = 8'h00;
    localparam logic [7:0] PAD_LEVEL_TH_RST = 8'h00;
    localparam logic [11:0] PAD_CONTROL_RST = 12'hE00;
    // =====================================================================
    // Control fields.
    localparam int PAD_EN_LSB = 0;
    localparam int PAD_SEL_LSB = 3;
    localparam int PAD_VF1_BIT = 9;
    localparam int PAD_VF2_BIT = 10;
    localparam int PAD_WF_BIT = 11;
    // =====================================================================
    // Lead select codes.
    localparam logic [1:0] PAD_LEAD_I = 2'h0;
    localparam logic [1:0] PAD_LEAD_II = 2'h1;
    localparam logic [1:0] PAD_LEAD_III = 2'h2;
    localparam logic [1:0] PAD_LEAD_AVF = 2'h3;
    // =====================================================================
    // Timing: sample rate and width window in microseconds.
    localparam int PAD_SAMPLE_KHZ = 128;
    localparam int PAD_MIN_WIDTH_US = 100;
    localparam int PAD_MAX_WIDTH_US = 2000;
    localparam int PAD_MIN_SAMPLES = (PAD_MIN_WIDTH_US * PAD_SAMPLE_KHZ + 999) / 1000;
    localparam int PAD_MAX_SAMPLES = (PAD_MAX_WIDTH_US * PAD_SAMPLE_KHZ) / 1000;
    localparam int PAD_FILT_SAMPLES = 2;
    localparam int PAD_GAIN_SHIFT = 3;
    typedef enum logic [1:0] {
        PAD_IDLE = 2'b00,
        PAD_RISE = 2'b01,
        PAD_HOLD = 2'b11
    } pad_state_t;
endpackage

/* File: core/pad_channel.sv */
// One pace detection state machine running on one selected lead.
// Assumes sample_stb marks a new 128 kHz 16-bit lead sample.
`timescale 1ns/10ps
`default_nettype none
module pad_channel (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Sample input.
    input wire logic sample_stb,
    input wire logic signed [15:0] lead_sample,
    // Thresholds and options.
    input wire logic enable,
    input wire logic [7:0] height_th,
    input wire logic [7:0] edge_th,
    input wire logic [7:0] level_th,
    input wire logic [1:0] gain_sel,
    input wire logic vf1_en,
    input wire logic vf2_en,
    input wire logic wf_en,
    // Result.
    output logic pace_pulse,
    output logic [7:0] width_r,
    output logic [15:0] height_r
);
    import pad_pkg::*;
    // =====================================================================
    // Threshold scaling, common to all three codes.
    function automatic logic [16:0] scale_code(input logic [7:0] code, input logic [1:0] g);
        if (g == 2'h3) begin
            scale_code = {1'b0, code, 8'h00} << 1;
        end else begin
            scale_code = {1'b0, code, 8'h00} >> (2'(PAD_GAIN_SHIFT - 1) - g);
        end
    endfunction
    function automatic logic [15:0] mag(input logic signed [15:0] v);
        mag = v[15] ? 16'(-v) : 16'(v);
    endfunction
    pad_state_t state_r;
    logic signed [15:0] base_r;
    logic polarity_r;
    logic [8:0] count_r;
    logic [15:0] peak_r;
    logic [1:0] filt_r;
    logic signed [16:0] delta;
    logic [16:0] dmag;
    logic [16:0] amp_th, edge_thr, lvl_thr;
    logic [16:0] trail_th;
    logic filt_ok;
    logic trail_hit;
    always_comb begin
        delta = 17'(lead_sample) - 17'(base_r);
        dmag = delta[16] ? 17'(-delta) : delta;
        amp_th = scale_code(height_th, gain_sel);
        edge_thr = (edge_th == 8'h00) ? (amp_th >> 1) : scale_code(edge_th, gain_sel);
        lvl_thr = scale_code(level_th[7] ? 8'(-level_th) : level_th, gain_sel);
        trail_th = {1'b0, peak_r} >> 1;
        filt_ok = (!vf1_en && !vf2_en) || (filt_r == 2'(PAD_FILT_SAMPLES));
        trail_hit = (delta != 17'sh0 && delta[16] != polarity_r) ||
            (dmag <= {1'b0, peak_r} && ({1'b0, peak_r} - dmag) >= trail_th);
    end
    // =====================================================================
    // Edge, peak and trailing edge search.
    always_ff @(posedge sys_clk) begin
        if (clk_en) pace_pulse <= 1'b0;
        if (!rst_n) begin
            pace_pulse <= 1'b0;
            state_r <= PAD_IDLE;
            base_r <= '0;
            polarity_r <= 1'b0;
            count_r <= '0;
            peak_r <= '0;
            filt_r <= '0;
            width_r <= '0;
            height_r <= '0;
        end else if (clk_en && sample_stb) begin
            unique case (state_r)
                PAD_IDLE: begin
                    if (enable && delta != 17'sh0 && dmag >= edge_thr) begin
                        state_r <= PAD_RISE;
                        polarity_r <= delta[16];
                        count_r <= 9'h001;
                        peak_r <= dmag[15:0];
                        filt_r <= '0;
                    end else begin
                        base_r <= lead_sample;
                    end
                end
                PAD_RISE: begin
                    count_r <= count_r + 9'h001;
                    if (delta[16] == polarity_r && dmag[15:0] > peak_r) begin
                        peak_r <= dmag[15:0];
                        if (filt_r != 2'(PAD_FILT_SAMPLES)) filt_r <= filt_r + 2'h1;
                    end else if ({1'b0, peak_r} >= amp_th && {1'b0, peak_r} >= lvl_thr) begin
                        state_r <= PAD_HOLD;
                    end
                    if (count_r >= 9'(PAD_MAX_SAMPLES)) begin
                        state_r <= PAD_IDLE;
                        base_r <= lead_sample;
                    end
                end
                PAD_HOLD: begin
                    count_r <= count_r + 9'h001;
                    if (trail_hit) begin
                        state_r <= PAD_IDLE;
                        base_r <= lead_sample;
                        if ((!wf_en || count_r >= 9'(PAD_MIN_SAMPLES)) && filt_ok) begin
                            pace_pulse <= 1'b1;
                            width_r <= count_r[7:0];
                            height_r <= peak_r;
                        end
                    end else if (count_r >= 9'(PAD_MAX_SAMPLES)) begin
                        state_r <= PAD_IDLE;
                        base_r <= lead_sample;
                    end
                end
                default: state_r <= PAD_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: test/pad_top_properties.sv */
// Port checker for the pacing artifact detector.
// Assumes pad_pkg is compiled first; bound to pad_top below.
`timescale 1ns/10ps
`default_nettype none
module pad_top_properties (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register and header.
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [23:0] reg_rdata,
    input wire logic frame_start,
    input wire logic [2:0] header_pace_flags,
    // Pins.
    input wire logic sec_port_en,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe
);
    import pad_pkg::*;
    // ====================================
    // Properties.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_read(logic [5:0] a);
        clk_en && reg_rd && reg_addr == a;
    endsequence
    a_reset_clear: assert property (disable iff (1'b0)
        !rst_n && clk_en |=> header_pace_flags == 3'h0 && pin_oe == 4'h0)
        else $error("outputs not cleared by reset");
    a_flag_hold: assert property (clk_en && !frame_start |=> $stable(header_pace_flags))
        else $error("header flags moved outside frame start");
    a_height_width: assert property (s_read(PAD_ADDR_HEIGHT_TH) |=> reg_rdata[23:8] == 16'h0)
        else $error("height threshold wider than 8 bits");
    a_edge_width: assert property (s_read(PAD_ADDR_EDGE_TH) |=> reg_rdata[23:8] == 16'h0)
        else $error("edge threshold wider than 8 bits");
    a_level_width: assert property (s_read(PAD_ADDR_LEVEL_TH) |=> reg_rdata[23:8] == 16'h0)
        else $error("level threshold wider than 8 bits");
    a_summary_bits: assert property (s_read(PAD_ADDR_RESULT) |=> reg_rdata[23:7] == 17'h0)
        else $error("summary word exceeds seven bits");
    a_spare_pin: assert property (clk_en && sec_port_en |=>
        pin_out[3] == $past(gpio_out[3]) && pin_oe[3] == $past(gpio_oe[3]))
        else $error("spare pin not passed through");
    a_port_pins: assert property (clk_en && sec_port_en |=> pin_oe[2:0] == 3'h7)
        else $error("serial port pins not driven");
    a_gpio_pass: assert property (clk_en && !sec_port_en |=>
        pin_out == $past(gpio_out) && pin_oe == $past(gpio_oe))
        else $error("general pins not passed through");
    a_frame_busy: assert property ($past(clk_en) && $past(sec_port_en) && pin_out[1] |->
        pin_out[0])
        else $error("frame pin without busy pin");
endmodule
bind pad_top pad_top_properties pad_top_properties_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .frame_start(frame_start),
    .header_pace_flags(header_pace_flags), .sec_port_en(sec_port_en),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_out(pin_out), .pin_oe(pin_oe)
);
`default_nettype wire

/* File: test/pad_host.sv */
// Host model that reaches the detector registers.
// Assumes requests change on the falling edge of sys_clk.
`timescale 1ns/10ps
`default_nettype none
module pad_host (
    // Clock.
    input wire logic sys_clk,
    // Register port.
    output logic reg_wr,
    output logic reg_rd,
    output logic [1:0] reg_unit,
    output logic [5:0] reg_addr,
    output logic [23:0] reg_wdata,
    input wire logic [23:0] reg_rdata
);
    // ====================================
    // Access task; released address and data lines show inverted values.
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_unit = 2'h0;
        reg_addr = 6'h00;
        reg_wdata = 24'h000000;
    end
    task automatic access(input logic wr, input logic [1:0] unit, input logic [5:0] addr,
            input logic [23:0] data, output logic [23:0] rdata);
        @(negedge sys_clk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_unit = unit;
        reg_addr = addr;
        reg_wdata = data;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
        @(negedge sys_clk);
        rdata = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the pacing artifact detector.
// Assumes lead I equals channel one while channels two and three rest at zero.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pad_pkg::*;
    typedef struct packed {
        logic wr;
        logic [1:0] unit;
        logic [5:0] addr;
        logic [23:0] data;
    } pad_row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [1:0] gain_sel = 2'h2;
    logic [47:0] stream;
    logic reg_wr, reg_rd;
    logic [1:0] reg_unit;
    logic [5:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata, rd;
    logic sample_stb = 1'b0;
    logic frame_start = 1'b0;
    logic sec_port_en = 1'b0;
    logic signed [15:0] ch1_raw = 16'sh0000;
    logic [2:0] header_pace_flags;
    logic [3:0] gpio_out = 4'h0;
    logic [3:0] gpio_oe = 4'h0;
    logic [3:0] pin_out, pin_oe;
    int fails = 0;
    int samples_checked = 0;
    // Rows: write flag, unit, index, data or expected read value.
    localparam pad_row_t ROWS [0:9] = '{'{1'b0, 2'h0, 6'h07, 24'h24},
        '{1'b0, 2'h0, 6'h0E, 24'h0}, '{1'b0, 2'h0, 6'h0F, 24'h0},
        '{1'b0, 2'h0, 6'h04, 24'hE00}, '{1'b1, 2'h1, 6'h07, 24'h55},
        '{1'b0, 2'h1, 6'h07, 24'h55}, '{1'b0, 2'h0, 6'h07, 24'h24},
        '{1'b1, 2'h2, 6'h0F, 24'hFF}, '{1'b0, 2'h2, 6'h0F, 24'hFF},
        '{1'b0, 2'h0, 6'h20, 24'h0}};
    always #2.5 sys_clk = ~sys_clk;
    pad_top pad_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_unit(reg_unit), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sample_stb(sample_stb), .ch1_raw(ch1_raw),
        .ch2_raw(16'sh0000), .ch3_raw(16'sh0000), .gain_sel(gain_sel),
        .frame_start(frame_start), .header_pace_flags(header_pace_flags),
        .sec_port_en(sec_port_en), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .pin_out(pin_out), .pin_oe(pin_oe));
    pad_host pad_host_i (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_unit(reg_unit), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    // ====================================
    // Tasks.
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (fails == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic samp(input logic signed [15:0] v);
        @(negedge sys_clk);
        ch1_raw = v;
        sample_stb = 1'b1;
        @(negedge sys_clk);
        sample_stb = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic frame(input logic exp);
        @(negedge sys_clk);
        frame_start = 1'b1;
        @(negedge sys_clk);
        frame_start = 1'b0;
        check({21'h0, header_pace_flags}, {23'h0, exp});
    endtask
    task automatic pulse(input logic [11:0] ctrl, input logic signed [15:0] amp,
            input int width, input logic exp);
        pad_host_i.access(1'b1, 2'h0, PAD_ADDR_CONTROL, {12'h000, ctrl}, rd);
        repeat (4) samp(16'sh0000);
        samp(amp >>> 1);
        samp(amp - (amp >>> 2));
        repeat (width) samp(amp);
        repeat (8) samp(16'sh0000);
        frame(exp);
        frame(1'b0);
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        stop_test();
    end
    // ====================================
    // Main sequence.
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        foreach (ROWS[i]) begin
            pad_host_i.access(ROWS[i].wr, ROWS[i].unit, ROWS[i].addr, ROWS[i].data, rd);
            if (!ROWS[i].wr) check(rd, ROWS[i].data);
        end
        pulse(12'hE01, 16'sh4000, 40, 1'b1);
        pad_host_i.access(1'b0, 2'h0, PAD_ADDR_EXT0, 24'h0, rd);
        check({16'h0, rd[23:16]}, 24'h2A);
        check({8'h0, rd[15:0]}, 24'h4000);
        pad_host_i.access(1'b0, 2'h0, PAD_ADDR_RESULT, 24'h0, rd);
        check(rd, 24'h12);
        pulse(12'hE01, -16'sh4000, 40, 1'b1);
        pulse(12'hE01, 16'sh1000, 40, 1'b0);
        gain_sel = 2'h1;
        pulse(12'hE01, 16'sh2000, 40, 1'b1);
        gain_sel = 2'h3;
        pulse(12'hE01, 16'sh2000, 40, 1'b0);
        gain_sel = 2'h2;
        pulse(12'hE01, 16'sh4000, 2, 1'b0);
        pulse(12'h601, 16'sh4000, 2, 1'b1);
        pulse(12'hE09, 16'sh4000, 40, 1'b0);
        pulse(12'hE01, 16'sh4000, 300, 1'b0);
        gpio_out = 4'hA;
        gpio_oe = 4'h9;
        sec_port_en = 1'b1;
        repeat (3) @(negedge sys_clk);
        check({22'h0, pin_out[3], pin_oe[3]}, 24'h3);
        @(negedge sys_clk);
        ch1_raw = 16'sh5A3C;
        sample_stb = 1'b1;
        @(negedge sys_clk);
        sample_stb = 1'b0;
        @(negedge sys_clk);
        check({21'h0, pin_out[2:0]}, 24'h3);
        for (int i = 0; i < 48; i++) begin
            stream = {stream[46:0], pin_out[2]};
            @(negedge sys_clk);
        end
        check(stream[47:24], 24'h5A3C00);
        check(stream[23:0], 24'h0);
        check({23'h0, pin_out[0]}, 24'h0);
        sec_port_en = 1'b0;
        repeat (2) @(negedge sys_clk);
        check({16'h0, pin_out, pin_oe}, 24'hA9);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        check({13'h0, header_pace_flags, pin_oe, pin_out}, 24'h0);
        rst_n = 1'b1;
        clk_en = 1'b0;
        pad_host_i.access(1'b1, 2'h1, PAD_ADDR_HEIGHT_TH, 24'h11, rd);
        clk_en = 1'b1;
        pad_host_i.access(1'b0, 2'h1, PAD_ADDR_HEIGHT_TH, 24'h0, rd);
        check(rd, 24'h24);
        stop_test();
    end
endmodule
`default_nettype wire
